// >>> common/hcc_defs.svh
// Constants for the high-speed system clock control block.
// Assumes inclusion by bare name from the package; the design uses its macros through that include.
`ifndef HCC_DEFS_SVH
`define HCC_DEFS_SVH

`define HCC_CLK_MHZ 50
`define HCC_GAIN_HALT_NS 5000
`define HCC_STAB_W 8
`define HCC_DIV_W 3
`define HCC_DIV_RESET 3'h1
`define HCC_DIV_MAX 3'h4
`define HCC_CNT_W 4
`define HCC_HALT_W 9
`define HCC_GAIN_RESET 1'b0

`endif

// >>> common/hcc_pkg.sv
// Types for the high-speed system clock control block.
// Assumes hcc_defs.svh is on the include path.
`default_nettype none
package hcc_pkg;
`include "hcc_defs.svh"

   // Pin mode, Gray coded along port -> resonator -> external input
   typedef enum logic [1:0] {
      HCC_PORT  = 2'h0,
      HCC_RESON = 2'h1,
      HCC_EXTIN = 2'h3
   } hcc_pin_mode_e;

   // Control bits written by software
   typedef struct packed {
      logic gain_wr;
      logic osc_gain_select;
      logic ext_input_select;
      logic osc_pin_enable;
      logic hs_clock_stop;
      logic main_source_select;
      logic peripheral_source_select;
      logic cpu_source_select;
      logic [`HCC_DIV_W-1:0] cpu_div;
   } hcc_ctrl_s;

   // GPIO drive for the two shared pins in port mode, and for pin A also in external input mode
   typedef struct packed {
      logic a_out;
      logic a_oe;
      logic b_out;
      logic b_oe;
   } hcc_gpio_s;

   // Status read back by software
   typedef struct packed {
      logic osc_gain_select;
      logic gain_locked;
      hcc_pin_mode_e pin_mode;
      logic main_clock_status_flag;
      logic cpu_clock_status_flag;
      logic [`HCC_DIV_W-1:0] cpu_div;
      logic [`HCC_STAB_W-1:0] stabilization_status_counter;
   } hcc_status_s;

   // Whole state of the block
   typedef struct packed {
      logic [2:0] sync;
      logic hs_level;
      logic gain;
      logic gain_locked;
      logic [`HCC_HALT_W-1:0] halt_cnt;
      logic hs_run;
      hcc_pin_mode_e pin_mode;
      logic main_sel;
      logic periph_sel;
      logic [`HCC_DIV_W-1:0] div_code;
      logic [`HCC_CNT_W-1:0] div_cnt;
      logic [`HCC_STAB_W-1:0] stab_cnt;
      logic main_tick;
      logic periph_tick;
      logic cpu_tick;
   } hcc_state_s;

endpackage
`default_nettype wire

// >>> src/hcc_clock_ctrl.sv
// High-speed system clock control: pin mode, gain, start/stop,
// stabilization count, source selection and CPU divider.
// Assumes the internal and alternate clocks arrive as one-cycle ticks
// on i_clock; the high-speed clock pin and oscillator are asynchronous.
`default_nettype none

module hcc_clock_ctrl
   import hcc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire hcc_ctrl_s i_ctrl,
   input wire hcc_gpio_s i_gpio,
   input wire logic i_stop_insn,
   input wire logic i_pin_b_in,
   input wire logic i_osc_out,
   input wire logic i_ihs_tick,
   input wire logic i_alt_tick,
   output logic o_pin_a_out,
   output logic o_pin_a_oe,
   output logic o_pin_b_out,
   output logic o_pin_b_oe,
   output logic o_amp_en,
   output logic o_high_gain,
   output logic o_ext_in_en,
   output logic o_cpu_halt,
   output logic o_main_tick,
   output logic o_periph_tick,
   output logic o_cpu_tick,
   output hcc_status_s o_status
);

   localparam logic [`HCC_HALT_W-1:0] HALT_CYC = `HCC_HALT_W'(
      (`HCC_GAIN_HALT_NS * `HCC_CLK_MHZ + 999) / 1000);

   hcc_state_s st_r;
   hcc_state_s st_nxt;
   logic hs_src;
   logic hs_edge;
   logic [`HCC_CNT_W-1:0] div_last;

   // Resonator output or pin B clock, chosen by the registered mode
   assign hs_src = (st_r.pin_mode == HCC_EXTIN) ? i_pin_b_in : i_osc_out;
   // Rising edge once the last two sync stages agree
   assign hs_edge = st_r.sync[1] & st_r.sync[2] & ~st_r.hs_level &
                    st_r.hs_run;
   assign div_last = (`HCC_CNT_W'(1) << st_r.div_code) - `HCC_CNT_W'(1);

   // Next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.sync = {st_r.sync[1:0], hs_src};
      if (st_r.sync[1] == st_r.sync[2]) begin
         st_nxt.hs_level = st_r.sync[2];
      end
      if (i_ctrl.gain_wr && !st_r.gain_locked) begin
         st_nxt.gain_locked = 1'b1;
         st_nxt.gain = i_ctrl.osc_gain_select;
         if (i_ctrl.osc_gain_select) begin
            st_nxt.halt_cnt = HALT_CYC;
         end
      end else if (st_r.halt_cnt != '0) begin
         st_nxt.halt_cnt = st_r.halt_cnt - `HCC_HALT_W'(1);
      end
      // port mode until pin enable set
      case ({i_ctrl.ext_input_select, i_ctrl.osc_pin_enable})
         2'h1: st_nxt.pin_mode = HCC_RESON;
         2'h3: st_nxt.pin_mode = HCC_EXTIN;
         default: st_nxt.pin_mode = HCC_PORT;
      endcase
      st_nxt.hs_run = (st_nxt.pin_mode != HCC_PORT) &&
                      !i_ctrl.hs_clock_stop && !i_stop_insn;
      if (!st_r.hs_run) begin
         st_nxt.stab_cnt = '0;
      end else if (hs_edge && (st_r.stab_cnt != '1)) begin
         st_nxt.stab_cnt = st_r.stab_cnt + `HCC_STAB_W'(1);
      end
      if (!i_ihs_tick && !hs_edge) begin
         st_nxt.main_sel = i_ctrl.main_source_select;
         st_nxt.periph_sel = i_ctrl.main_source_select |
                             i_ctrl.peripheral_source_select;
      end
      st_nxt.main_tick = st_r.main_sel ? hs_edge : i_ihs_tick;
      st_nxt.periph_tick = st_r.periph_sel ? hs_edge : i_ihs_tick;
      st_nxt.cpu_tick = 1'b0;
      if (st_nxt.main_tick) begin
         if (st_r.div_cnt >= div_last) begin
            st_nxt.div_cnt = '0;
            st_nxt.cpu_tick = !i_ctrl.cpu_source_select;
            if (i_ctrl.cpu_div <= `HCC_DIV_MAX) begin
               st_nxt.div_code = i_ctrl.cpu_div;
            end
         end else begin
            st_nxt.div_cnt = st_r.div_cnt + `HCC_CNT_W'(1);
         end
      end
      // alternate source when select is one
      if (i_ctrl.cpu_source_select) begin
         st_nxt.cpu_tick = i_alt_tick;
      end
      if (st_nxt.halt_cnt != '0) begin
         st_nxt.cpu_tick = 1'b0;
      end
   end

   // State register
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_r <= '0;
         st_r.gain <= `HCC_GAIN_RESET;
         st_r.pin_mode <= HCC_PORT;
         st_r.div_code <= `HCC_DIV_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Pin drive: GPIO in port mode, pin A also in external input mode
   assign o_pin_a_out = i_gpio.a_out;
   assign o_pin_a_oe = (st_r.pin_mode != HCC_RESON) & i_gpio.a_oe;
   assign o_pin_b_out = i_gpio.b_out;
   assign o_pin_b_oe = (st_r.pin_mode == HCC_PORT) & i_gpio.b_oe;
   assign o_high_gain = st_r.gain;
   assign o_amp_en = st_r.hs_run & (st_r.pin_mode == HCC_RESON);
   assign o_ext_in_en = st_r.hs_run & (st_r.pin_mode == HCC_EXTIN);
   assign o_cpu_halt = (st_r.halt_cnt != '0);
   assign o_main_tick = st_r.main_tick;
   assign o_periph_tick = st_r.periph_tick;
   assign o_cpu_tick = st_r.cpu_tick;

   // Status fields
   always_comb begin
      o_status.osc_gain_select = st_r.gain;
      o_status.gain_locked = st_r.gain_locked;
      o_status.pin_mode = st_r.pin_mode;
      o_status.main_clock_status_flag = st_r.main_sel;
      o_status.cpu_clock_status_flag = i_ctrl.cpu_source_select;
      o_status.cpu_div = st_r.div_code;
      o_status.stabilization_status_counter = st_r.stab_cnt;
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   sequence s_gain_set;
      i_ctrl.gain_wr && i_ctrl.osc_gain_select && !st_r.gain_locked;
   endsequence
   sequence s_halt_hold;
      o_cpu_halt [*8];
   endsequence
   // Last halted cycle, then the CPU clock resumes
   sequence s_halt_end;
      o_cpu_halt ##1 !o_cpu_halt;
   endsequence

   a_port_default: assert property (
      !$past(i_ctrl.osc_pin_enable) |-> o_pin_b_oe == i_gpio.b_oe)
      else $error("pins not in port mode");
   a_gain_level: assert property (
      $past(i_ctrl.gain_wr && !st_r.gain_locked) |->
      o_high_gain == $past(i_ctrl.osc_gain_select))
      else $error("gain not taken");
   a_gain_once: assert property (
      $past(st_r.gain_locked) |-> $stable(o_high_gain))
      else $error("gain changed after lock");
   // 8 held plus 242 more cycles make the full 250-cycle halt
   a_gain_halt: assert property (
      s_gain_set |=> s_halt_hold ##242 s_halt_end)
      else $error("halt length wrong");
   a_halt_notick: assert property (
      o_cpu_halt |-> !o_cpu_tick)
      else $error("cpu tick during halt");
   a_reson_mode: assert property (
      $past(i_ctrl.osc_pin_enable && !i_ctrl.ext_input_select) |->
      !o_pin_a_oe && !o_pin_b_oe)
      else $error("resonator mode pins driven");
   a_ext_mode: assert property (
      $past(i_ctrl.osc_pin_enable && i_ctrl.ext_input_select) |->
      !o_pin_b_oe && o_pin_a_oe == i_gpio.a_oe)
      else $error("external mode pins wrong");
   a_stop_clock: assert property (
      (i_ctrl.hs_clock_stop || i_stop_insn) |=> !o_amp_en && !o_ext_in_en)
      else $error("clock not stopped");
   a_start_clock: assert property (
      (i_ctrl.osc_pin_enable && !i_ctrl.hs_clock_stop && !i_stop_insn)
      ##1 1'b1 |-> (o_amp_en || o_ext_in_en))
      else $error("clock not started");
   a_periph_forced: assert property (
      st_r.main_sel |-> st_r.periph_sel)
      else $error("peripheral not forced");
   a_div_legal: assert property (
      st_r.div_code <= `HCC_DIV_MAX)
      else $error("illegal divider code");
   a_div_wrap: assert property (
      $changed(st_r.div_code) |-> st_r.div_cnt == '0)
      else $error("ratio changed mid period");

endmodule // hcc_clock_ctrl
`default_nettype wire

// >>> tb/hcc_xtal_model.sv
// Resonator / external clock source model for the clock control bench.
// Assumes the bench clock; the source edges land 1 ns after its edges.
`default_nettype none
module hcc_xtal_model (
   input wire logic i_clock,
   input wire logic i_amp_en,
   input wire logic i_ext_in_en,
   input wire logic [3:0] i_half,
   output logic o_osc_out,
   output logic o_pin_b_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt = 4'h0;
   logic ph = 1'b0;
   logic wob = 1'b0;
   // Half period in bench cycles; a larger value models a slow source
   always @(posedge i_clock) begin
      cnt <= #1 (cnt + 4'h1 >= i_half) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'h0)
         ph <= #1 ~ph;
      wob <= #1 ~wob;
   end
   // Idle lines wobble so a stale level is never mistaken for a clock
   assign o_osc_out = i_amp_en ? ph : wob;
   assign o_pin_b_in = i_ext_in_en ? ph : wob;
endmodule // hcc_xtal_model
`default_nettype wire

// >>> tb/hcc_clock_ctrl_tb.sv
// Self-checking bench for the high-speed clock control block.
// Assumes the source model file; controls change 1 ns after edges.
`default_nettype none
module hcc_clock_ctrl_tb;
   import hcc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
      n_mismatch++; $display("ERROR %0t mismatch", $time); end end
   logic i_clock = 1'b0, i_rst = 1'b1, i_stop_insn = 1'b0;
   logic ihs = 1'b0, alt = 1'b0, osc, pin_b, amp, ext, halt, mt, pt, ct;
   logic a_oe, b_oe, high_gain, a_out, b_out;
   hcc_ctrl_s ctl = '0;
   // All GPIO bits set so every pass-through shows against zero
   hcc_gpio_s gp = 4'hf;
   hcc_status_s st;
   int n_mismatch = 0, cmp_count = 0, n, m;
   hcc_clock_ctrl hcc_clock_ctrl_i (.i_clock(i_clock), .i_rst(i_rst),
      .i_ctrl(ctl), .i_gpio(gp), .i_stop_insn(i_stop_insn),
      .i_pin_b_in(pin_b), .i_osc_out(osc), .i_ihs_tick(ihs),
      .i_alt_tick(alt), .o_pin_a_out(a_out), .o_pin_a_oe(a_oe),
      .o_pin_b_out(b_out), .o_pin_b_oe(b_oe), .o_amp_en(amp),
      .o_high_gain(high_gain), .o_ext_in_en(ext), .o_cpu_halt(halt),
      .o_main_tick(mt), .o_periph_tick(pt), .o_cpu_tick(ct),
      .o_status(st));
   hcc_xtal_model hcc_xtal_model_i (.i_clock(i_clock), .i_amp_en(amp),
      .i_ext_in_en(ext), .i_half(4'h3), .o_osc_out(osc),
      .o_pin_b_in(pin_b));
   initial begin
      forever #10 i_clock = ~i_clock;
   end
   // Internal oscillator tick every second cycle
   always @(posedge i_clock) ihs <= #1 ~ihs & ~i_rst;
   task automatic cyc(input int k);
      repeat (k) begin
         @(posedge i_clock);
         #1;
      end
   endtask
   task automatic end_of_test;
      $display("Counts: %0d compares, %0d mismatches", cmp_count,
         n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Cycles between two CPU ticks, bounded
   task automatic cpu_gap(output int g);
      g = 0;
      while (ct !== 1'b1 && g < 200) begin g++; cyc(1); end
      if (g >= 200) begin
         n_mismatch++;
         $display("ERROR %0t no cpu tick", $time);
         end_of_test();
      end
      g = 0;
      cyc(1);
      while (ct !== 1'b1 && g < 200) begin g++; cyc(1); end
      g++;
      if (g > 200) begin
         n_mismatch++;
         $display("ERROR %0t no cpu tick", $time);
         end_of_test();
      end
   endtask
   initial begin
      ctl.hs_clock_stop = 1'b1;
      ctl.cpu_div = 3'h1;
      cyc(10);
      i_rst = 1'b0;
      cyc(1);
      `CHK(st.pin_mode, HCC_PORT)
      `CHK({a_oe, b_oe, high_gain, halt}, 4'hc)
      `CHK({a_out, b_out}, 2'h3)
      `CHK(st.cpu_div, 3'h1)
      $display("test reset done");
      ctl.gain_wr = 1'b1;
      ctl.osc_gain_select = 1'b1;
      cyc(1);
      ctl.gain_wr = 1'b0;
      `CHK(high_gain, 1'b1)
      n = 0;
      // Halt length counted, no CPU tick may leak through it
      while (halt === 1'b1 && n < 400) begin
         if (ct !== 1'b0) `CHK(ct, 1'b0)
         n++;
         cyc(1);
      end
      `CHK(n, 250)
      ctl.gain_wr = 1'b1;
      ctl.osc_gain_select = 1'b0;
      cyc(1);
      ctl.gain_wr = 1'b0;
      cyc(1);
      `CHK({high_gain, halt}, 2'h2)
      $display("test gain done");
      // Divider ratios on the internal tick, then a prohibited code
      for (int c = 0; c < 6; c++) begin
         ctl.cpu_div = c[2:0];
         cpu_gap(n);
         cpu_gap(n);
         `CHK(n, 2 << (c > 4 ? 4 : c))
      end
      ctl.cpu_div = 3'h0;
      // Alternate CPU source: its tick shows one cycle later
      ctl.cpu_source_select = 1'b1;
      alt = 1'b1;
      cyc(1);
      alt = 1'b0;
      `CHK({ct, st.cpu_clock_status_flag}, 2'h3)
      cyc(1);
      `CHK(ct, 1'b0)
      ctl.cpu_source_select = 1'b0;
      $display("test divider done");
      ctl.osc_pin_enable = 1'b1;
      cyc(2);
      `CHK({st.pin_mode, a_oe, b_oe, amp}, {HCC_RESON, 3'h0})
      ctl.hs_clock_stop = 1'b0;
      cyc(40);
      `CHK(amp, 1'b1)
      `CHK(st.stabilization_status_counter != 8'h0, 1'b1)
      ctl.main_source_select = 1'b1;
      n = 0;
      // Peripheral clock tied to the high-speed main clock
      repeat (60) begin
         cyc(1);
         `CHK(pt, mt)
         n += mt;
      end
      `CHK(n > 0 && st.main_clock_status_flag === 1'b1, 1'b1)
      ctl.main_source_select = 1'b0;
      ctl.peripheral_source_select = 1'b1;
      cyc(8);
      n = 0;
      m = 0;
      // Peripheral alone on the high-speed clock, main on the internal
      repeat (12) begin
         cyc(1);
         n += pt;
         m += mt;
      end
      `CHK(n, 2)
      `CHK(m, 6)
      ctl.peripheral_source_select = 1'b0;
      cyc(2);
      i_stop_insn = 1'b1;
      cyc(4);
      `CHK({amp, st.stabilization_status_counter}, 9'h0)
      i_stop_insn = 1'b0;
      ctl.hs_clock_stop = 1'b1;
      cyc(4);
      `CHK(amp, 1'b0)
      $display("test resonator done");
      ctl.ext_input_select = 1'b1;
      cyc(2);
      `CHK({st.pin_mode, a_oe, b_oe}, {HCC_EXTIN, 2'h2})
      ctl.hs_clock_stop = 1'b0;
      cyc(2);
      `CHK({ext, amp}, 2'h2)
      ctl.hs_clock_stop = 1'b1;
      cyc(2);
      `CHK(ext, 1'b0)
      $display("test external done");
      end_of_test();
   end
endmodule // hcc_clock_ctrl_tb
`default_nettype wire
